// ---- hdl/svid_bank_consts.vh ----
// Constants for the serial VID register bank: register indices, reset values,
// frame layout, command and acknowledge codes, ramp timing.
// Assumes inclusion by the bank module and the self-checking bench.
`ifndef SVID_BANK_CONSTS_VH
`define SVID_BANK_CONSTS_VH

`define REG_STATUS_TWO          8'h11
`define REG_STATUS_TWO_SNAPSHOT 8'h1c
`define REG_MAX_CURRENT_LIMIT   8'h21
`define REG_MAX_TEMP_LIMIT      8'h22
`define REG_FAST_SLEW_RATE      8'h24
`define REG_SLOW_SLEW_RATE      8'h25
`define REG_STARTUP_VOLTAGE     8'h26
`define REG_MAX_OUTPUT_CODE     8'h30
`define REG_PROGRAMMED_CODE     8'h31
`define REG_POWER_STATE         8'h32
`define REG_MARGIN_STEPS        8'h33

`define RST_SNAPSHOT            8'h00
`define RST_MAX_CURRENT         8'h00
`define RST_MAX_TEMP            8'h64
`define RST_FAST_SLEW           8'h0a
`define RST_SLOW_SLEW           8'h02
`define RST_STARTUP_VOLTAGE     8'h00
`define RST_MAX_OUTPUT_CODE     8'hb5
`define RST_PROGRAMMED_CODE     8'h00
`define RST_POWER_STATE         8'h00
`define RST_MARGIN_STEPS        8'h00

`define CMD_SETVID_FAST         5'h01
`define CMD_SETVID_SLOW         5'h02
`define CMD_SET_POWER_STATE     5'h04
`define CMD_GET_REG             5'h07
`define CMD_SET_REG_ADDR        5'h08
`define CMD_SET_REG_DATA        5'h09

`define ACK_OK                  2'b10
`define ACK_NOT_SUPPORTED       2'b01

`define FRAME_START             3'b010
`define FRAME_END               3'b011
`define FRAME_BODY_BITS         5'd21

`define STRAP_SETTLE_CYCLES     4'h8
`define RAMP_FAST_CYCLES        16
`define SLOW_RAMP_RATIO         5

`endif

// ---- hdl/svid_register_bank.v ----
// Serial VID register bank: upper register set of a regulator controller,
// reached by the bus master over a clocked serial data line.
// Assumes bus clock and data arrive asynchronously; status and temperature
// inputs come from logic on I_MCLK.
`timescale 1ns/1ps
`include "svid_bank_consts.vh"

module svid_register_bank #(
   parameter [3:0] DEVICE_ADDR       = 4'h0,
   parameter [7:0] BOOT_CODE         = `RST_STARTUP_VOLTAGE,
   parameter       RAMP_FAST_CYCLES  = `RAMP_FAST_CYCLES,
   parameter       SLOW_RAMP_RATIO   = `SLOW_RAMP_RATIO
) (
   input  wire       I_MCLK,
   input  wire       I_NRST,
   input  wire       I_SVID_CLK,
   input  wire       I_SVID_DATA,
   input  wire [7:0] I_MAX_CURRENT_STRAP_PIN,
   input  wire [7:0] I_STATUS_TWO,
   input  wire [7:0] I_PLATFORM_TEMP,
   output reg        O_SVID_DATA,
   output reg        O_SVID_DATA_OE,
   output reg        O_REGULATOR_HOT_FLAG,
   output reg  [7:0] O_OUTPUT_CODE,
   output reg  [7:0] O_POWER_STATE
);

   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_RX   = 3'd1;
   localparam [2:0] ST_TA   = 3'd2;
   localparam [2:0] ST_TX   = 3'd3;
   localparam       RAMP_SLOW_CYCLES = RAMP_FAST_CYCLES * SLOW_RAMP_RATIO;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection
   reg  [2:0]  clk_sync;
   reg  [1:0]  data_sync;
   reg  [7:0]  strap_meta;
   reg  [7:0]  strap_sync;
   wire        rise = clk_sync[1] & ~clk_sync[2];
   wire        fall = ~clk_sync[1] & clk_sync[2];
   wire        din  = data_sync[1];

   always @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         clk_sync   <= 3'h0;
         data_sync  <= 2'h3;
         strap_meta <= 8'h00;
         strap_sync <= 8'h00;
      end else begin
         clk_sync   <= {clk_sync[1:0], I_SVID_CLK};
         data_sync  <= {data_sync[0], I_SVID_DATA};
         strap_meta <= I_MAX_CURRENT_STRAP_PIN;
         strap_sync <= strap_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   reg  [7:0]  status_two_snapshot;
   reg  [7:0]  max_current_limit;
   reg  [7:0]  max_temperature_limit;
   reg  [7:0]  max_output_code;
   reg  [7:0]  programmed_voltage_code;
   reg  [7:0]  voltage_margin_steps;
   reg  [7:0]  reg_addr;
   reg  [3:0]  settle_cnt;
   reg         strap_taken;
   reg         boot_hold;
   reg         slow_mode;

   wire [7:0]  fast_slew_rate  = `RST_FAST_SLEW;
   wire [7:0]  slow_slew_rate  = `RST_SLOW_SLEW;
   wire [7:0]  startup_voltage = BOOT_CODE;

   // Read mux; read-only registers are constants or hardware-owned
   reg  [7:0]  read_data;
   reg         read_ok;
   reg  [7:0]  read_index;
   always @* begin
      read_ok   = 1'b1;
      case (read_index)
         `REG_STATUS_TWO:          read_data = I_STATUS_TWO;
         `REG_STATUS_TWO_SNAPSHOT: read_data = status_two_snapshot;
         `REG_MAX_CURRENT_LIMIT:   read_data = max_current_limit;
         `REG_MAX_TEMP_LIMIT:      read_data = max_temperature_limit;
         `REG_FAST_SLEW_RATE:      read_data = fast_slew_rate;
         `REG_SLOW_SLEW_RATE:      read_data = slow_slew_rate;
         `REG_STARTUP_VOLTAGE:     read_data = startup_voltage;
         `REG_MAX_OUTPUT_CODE:     read_data = max_output_code;
         `REG_PROGRAMMED_CODE:     read_data = programmed_voltage_code;
         `REG_POWER_STATE:         read_data = O_POWER_STATE;
         `REG_MARGIN_STEPS:        read_data = voltage_margin_steps;
         default: begin
            read_data = 8'h00;
            read_ok   = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame receiver and command execution
   reg  [2:0]  state;
   reg  [2:0]  hunt;
   reg  [20:0] rx;
   reg  [4:0]  rx_cnt;
   reg  [10:0] tx;
   reg  [3:0]  tx_left;

   wire [20:0] body    = {rx[19:0], din};
   wire [3:0]  f_addr  = body[20:17];
   wire [4:0]  f_cmd   = body[16:12];
   wire [7:0]  f_pay   = body[11:4];
   wire        f_par   = body[3];
   wire        f_good  = (body[2:0] == `FRAME_END) && (^body[20:4] == f_par)
                         && (f_addr == DEVICE_ADDR);

   always @* begin
      read_index = (f_cmd == `CMD_GET_REG) ? f_pay : reg_addr;
   end

   always @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state                   <= ST_IDLE;
         hunt                    <= 3'h7;
         rx                      <= 21'h0;
         rx_cnt                  <= 5'h0;
         tx                      <= 11'h0;
         tx_left                 <= 4'h0;
         O_SVID_DATA             <= 1'b1;
         O_SVID_DATA_OE          <= 1'b0;
         status_two_snapshot     <= `RST_SNAPSHOT;
         max_current_limit       <= `RST_MAX_CURRENT;
         max_temperature_limit   <= `RST_MAX_TEMP;
         max_output_code         <= `RST_MAX_OUTPUT_CODE;
         programmed_voltage_code <= `RST_PROGRAMMED_CODE;
         O_POWER_STATE           <= `RST_POWER_STATE;
         voltage_margin_steps    <= `RST_MARGIN_STEPS;
         reg_addr                <= 8'h00;
         settle_cnt              <= 4'h0;
         strap_taken             <= 1'b0;
         boot_hold               <= 1'b1;
         slow_mode               <= 1'b0;
      end else begin
         // Strap sampled once after it has settled, then frozen
         if (!strap_taken) begin
            if (settle_cnt == `STRAP_SETTLE_CYCLES) begin
               max_current_limit <= strap_sync;
               strap_taken       <= 1'b1;
            end else begin
               settle_cnt <= settle_cnt + 4'h1;
            end
         end

         case (state)
            ST_IDLE: begin
               if (rise) begin
                  if ({hunt[1:0], din} == `FRAME_START) begin
                     state  <= ST_RX;
                     rx_cnt <= 5'h0;
                     hunt   <= 3'h7;
                  end else begin
                     hunt <= {hunt[1:0], din};
                  end
               end
            end
            ST_RX: begin
               if (rise) begin
                  rx     <= body;
                  rx_cnt <= rx_cnt + 5'h1;
                  if (rx_cnt == `FRAME_BODY_BITS - 5'd1) begin
                     // Bad parity, framing or other address: stay silent
                     state   <= f_good ? ST_TA : ST_IDLE;
                     tx_left <= 4'd2;
                     tx      <= {`ACK_OK, 9'h0};
                     case (f_cmd)
                        `CMD_SETVID_FAST, `CMD_SETVID_SLOW: begin
                           if (f_pay > max_output_code) begin
                              tx <= {`ACK_NOT_SUPPORTED, 9'h0};
                           end else if (f_good) begin
                              programmed_voltage_code <= f_pay;
                              slow_mode <= (f_cmd == `CMD_SETVID_SLOW);
                              boot_hold <= 1'b0;
                           end
                        end
                        `CMD_SET_POWER_STATE: begin
                           if (f_good) begin
                              O_POWER_STATE <= f_pay;
                           end
                        end
                        `CMD_GET_REG: begin
                           tx_left <= 4'd11;
                           tx <= {(read_ok ? `ACK_OK : `ACK_NOT_SUPPORTED),
                                  read_data, ^read_data};
                           if (f_good && f_pay == `REG_STATUS_TWO) begin
                              status_two_snapshot <= I_STATUS_TWO;
                           end
                        end
                        `CMD_SET_REG_ADDR: begin
                           if (f_good) begin
                              reg_addr <= f_pay;
                           end
                        end
                        `CMD_SET_REG_DATA: begin
                           // Read-only and unmapped targets keep their value
                           if (!f_good) begin
                              tx <= {`ACK_OK, 9'h0};
                           end else if (reg_addr == `REG_MAX_TEMP_LIMIT) begin
                              max_temperature_limit <= f_pay;
                           end else if (reg_addr == `REG_MAX_OUTPUT_CODE) begin
                              max_output_code <= f_pay;
                           end else if (reg_addr == `REG_PROGRAMMED_CODE) begin
                              programmed_voltage_code <= f_pay;
                              boot_hold <= 1'b0;
                           end else if (reg_addr == `REG_POWER_STATE) begin
                              O_POWER_STATE <= f_pay;
                           end else if (reg_addr == `REG_MARGIN_STEPS) begin
                              voltage_margin_steps <= f_pay;
                           end else begin
                              tx <= {`ACK_NOT_SUPPORTED, 9'h0};
                           end
                        end
                        default: tx <= {`ACK_NOT_SUPPORTED, 9'h0};
                     endcase
                  end
               end
            end
            ST_TA: begin
               // One falling edge of turnaround before the device drives
               if (fall) begin
                  state <= ST_TX;
               end
            end
            ST_TX: begin
               if (fall) begin
                  if (tx_left == 4'h0) begin
                     O_SVID_DATA_OE <= 1'b0;
                     O_SVID_DATA    <= 1'b1;
                     state          <= ST_IDLE;
                  end else begin
                     O_SVID_DATA_OE <= 1'b1;
                     O_SVID_DATA    <= tx[10];
                     tx             <= {tx[9:0], 1'b0};
                     tx_left        <= tx_left - 4'h1;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output target, ramp and hot flag
   // Margin is applied on top of the programmed code and clamped so that a
   // negative margin at code 00h cannot wrap to the top of the range.
   wire [9:0]  margined = {2'b00, programmed_voltage_code}
                          + {{2{voltage_margin_steps[7]}}, voltage_margin_steps};
   wire [7:0]  clamped  = margined[9] ? 8'h00 : (margined[8] ? 8'hff : margined[7:0]);
   wire [7:0]  target   = boot_hold ? startup_voltage : clamped;
   reg  [15:0] ramp_cnt;
   wire [15:0] ramp_len = slow_mode ? RAMP_SLOW_CYCLES[15:0] : RAMP_FAST_CYCLES[15:0];

   always @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         ramp_cnt             <= 16'h0000;
         O_OUTPUT_CODE        <= 8'h00;
         O_REGULATOR_HOT_FLAG <= 1'b0;
      end else begin
         O_REGULATOR_HOT_FLAG <= (I_PLATFORM_TEMP >= max_temperature_limit);
         if (ramp_cnt >= ramp_len - 16'h0001) begin
            ramp_cnt <= 16'h0000;
            // One VID step per tick; fast or slow pace follows the last accepted SetVID fast or slow command
            if (O_OUTPUT_CODE < target) begin
               O_OUTPUT_CODE <= O_OUTPUT_CODE + 8'h01;
            end else if (O_OUTPUT_CODE > target) begin
               O_OUTPUT_CODE <= O_OUTPUT_CODE - 8'h01;
            end
         end else begin
            ramp_cnt <= ramp_cnt + 16'h0001;
         end
      end
   end

endmodule // svid_register_bank

// ---- tb/svid_bank_checker_asserts.sv ----
// Checker for the serial VID bank, watching only its top-level ports.
// Assumes one I_MCLK domain and a bind onto svid_register_bank.
`timescale 1ns/1ps
module svid_bank_checker #(
   parameter RAMP_FAST_CYCLES = 16
) (
   input wire       I_MCLK,
   input wire       I_NRST,
   input wire       I_SVID_CLK,
   input wire [7:0] I_PLATFORM_TEMP,
   input wire       O_SVID_DATA,
   input wire       O_SVID_DATA_OE,
   input wire       O_REGULATOR_HOT_FLAG,
   input wire [7:0] O_OUTPUT_CODE,
   input wire [7:0] O_POWER_STATE
);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_NRST);
   reg [7:0] prev;
   integer   gap;
   integer   oe_len;
   ////////////////////////////////////////////////////////////////////////////////
   // Gap saturates so a long hold never wraps into a false short interval
   always @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         prev   <= 8'h00;
         gap    <= 1000;
         oe_len <= 0;
      end else begin
         prev   <= O_OUTPUT_CODE;
         gap    <= (O_OUTPUT_CODE != prev) ? 1 : ((gap < 1000) ? gap + 1 : gap);
         oe_len <= O_SVID_DATA_OE ? oe_len + 1 : 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_reset_outputs: assert property ($rose(I_NRST) |-> !O_SVID_DATA_OE && O_SVID_DATA
      && O_OUTPUT_CODE == 8'h00 && O_POWER_STATE == 8'h00) else $error("bad state after reset");
   a_idle_line: assert property (!O_SVID_DATA_OE |-> O_SVID_DATA)
      else $error("line not high while released");
   a_bit_stands: assert property (O_SVID_DATA_OE && I_SVID_CLK && $past(I_SVID_CLK)
      && $past(I_SVID_CLK, 2) |-> $stable(O_SVID_DATA)) else $error("bit moved in high phase");
   a_answer_min: assert property ($rose(O_SVID_DATA_OE) |-> O_SVID_DATA_OE[*8])
      else $error("answer dropped too early");
   a_answer_max: assert property (oe_len <= 96)
      else $error("answer held too long");
   a_power_quiet: assert property (O_SVID_DATA_OE |-> $stable(O_POWER_STATE))
      else $error("power state moved while answering");
   a_code_unit: assert property ($changed(O_OUTPUT_CODE) |->
      (O_OUTPUT_CODE - $past(O_OUTPUT_CODE) == 8'h01) ||
      ($past(O_OUTPUT_CODE) - O_OUTPUT_CODE == 8'h01)) else $error("output code jumped");
   a_code_gap: assert property ($changed(O_OUTPUT_CODE) |-> gap >= RAMP_FAST_CYCLES)
      else $error("output code stepped too fast");
   a_hot_at_max: assert property (I_PLATFORM_TEMP == 8'hff |=> O_REGULATOR_HOT_FLAG)
      else $error("hot flag low at full temperature");
endmodule // svid_bank_checker
bind svid_register_bank svid_bank_checker #(.RAMP_FAST_CYCLES(RAMP_FAST_CYCLES)) chk (
   .I_MCLK, .I_NRST, .I_SVID_CLK, .I_PLATFORM_TEMP, .O_SVID_DATA, .O_SVID_DATA_OE,
   .O_REGULATOR_HOT_FLAG, .O_OUTPUT_CODE, .O_POWER_STATE);

// ---- tb/svid_master_model.sv ----
// Bus master model: frames a command, clocks the answer, collects driven bits.
// Assumes the line has no pull; the bench calls xfer one frame at a time.
`timescale 1ns/1ps
module svid_master_model (
   output reg  o_clk,
   output wire o_line,
   input  wire i_dev_data,
   input  wire i_dev_oe
);
   reg drive;
   reg bit_out;
   // Released line shows the inverse of the last bit, so nothing stale reads as valid
   assign o_line = i_dev_oe ? i_dev_data : (drive ? bit_out : ~bit_out);
   initial begin
      o_clk   = 1'b0;
      drive   = 1'b0;
      bit_out = 1'b0;
   end
   task xfer(input [3:0] a, input [4:0] c, input [7:0] p, input bad,
             output [10:0] rsp, output integer n);
      reg [23:0] f;
      integer    k;
      begin
         f   = {3'b010, a, c, p, ^{a, c, p} ^ bad, 3'b011};
         rsp = 11'h000;
         n   = 0;
         #7 drive = 1'b1;
         for (k = 23; k >= 0; k = k - 1) begin
            bit_out = f[k];
            #160 o_clk = 1'b1;
            #160 o_clk = 1'b0;
         end
         drive = 1'b0;
         // Extra clocks cover the answer; the clock then stands still
         for (k = 0; k < 14; k = k + 1) begin
            #160 o_clk = 1'b1;
            if (i_dev_oe) begin
               rsp = {rsp[9:0], i_dev_data};
               n   = n + 1;
            end
            #160 o_clk = 1'b0;
         end
         // Tail keeps every frame on the same phase of the system clock,
         // so no link edge ever lands on a rising system clock edge
         #993;
      end
   endtask
endmodule // svid_master_model

// ---- tb/test_svid_register_bank.sv ----
// Self-checking bench for the serial VID register bank.
// Assumes svid_master_model as bus partner and the bound checker.
`timescale 1ns/1ps
`include "svid_bank_consts.vh"
`define CHK(a, e) begin n_checks = n_checks + 1; if ((a) !== (e)) begin \
   err_count = err_count + 1; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_svid_register_bank;
   localparam [79:0] RIDX = {8'h33, 8'h32, 8'h31, 8'h30, 8'h22, 8'h26, 8'h25, 8'h24, 8'h21, 8'h1c};
   localparam [23:0] OFS = {8'h00, 8'h01, 8'hff};
   // Nonzero boot code so the start-up ramp is visible on the output
   localparam [7:0]  BOOT = 8'h05;
   reg         mclk, nrst;
   reg  [7:0]  strap, status, temp, s0, lim, vid, ps, t22;
   reg  [10:0] rsp;
   integer     err_count, n_checks, n, i, j;
   wire        sclk, sline, dout, doe, hot;
   wire [7:0]  code, pstate;
   svid_register_bank #(.BOOT_CODE(BOOT), .RAMP_FAST_CYCLES(2), .SLOW_RAMP_RATIO(2)) dut (
      .I_MCLK(mclk), .I_NRST(nrst), .I_SVID_CLK(sclk), .I_SVID_DATA(sline),
      .I_MAX_CURRENT_STRAP_PIN(strap), .I_STATUS_TWO(status), .I_PLATFORM_TEMP(temp),
      .O_SVID_DATA(dout), .O_SVID_DATA_OE(doe), .O_REGULATOR_HOT_FLAG(hot),
      .O_OUTPUT_CODE(code), .O_POWER_STATE(pstate));
   svid_master_model bus (.o_clk(sclk), .o_line(sline), .i_dev_data(dout), .i_dev_oe(doe));
   ////////////////////////////////////////////////////////////////////////////////
   function [7:0] dflt(input [7:0] r);
      case (r)
         8'h21:   dflt = s0;
         8'h22:   dflt = `RST_MAX_TEMP;
         8'h24:   dflt = `RST_FAST_SLEW;
         8'h25:   dflt = `RST_SLOW_SLEW;
         8'h26:   dflt = BOOT;
         8'h30:   dflt = `RST_MAX_OUTPUT_CODE;
         default: dflt = 8'h00;
      endcase
   endfunction
   function [7:0] mg(input [7:0] v, input [7:0] o);
      integer s;
      begin
         s  = v;
         s  = s + $signed(o);
         mg = (s < 0) ? 8'h00 : ((s > 255) ? 8'hff : s[7:0]);
      end
   endfunction
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", n_checks, err_count);
         if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task rd(input [7:0] r, input [1:0] a, input [7:0] d);
      begin
         bus.xfer(4'h0, `CMD_GET_REG, r, 1'b0, rsp, n);
         `CHK({n[3:0], rsp}, {4'd11, a, d, ^d})
      end
   endtask
   task cm(input [4:0] c, input [7:0] p, input [1:0] a);
      begin
         bus.xfer(4'h0, c, p, 1'b0, rsp, n);
         `CHK({n[3:0], rsp[1:0]}, {4'd2, a})
      end
   endtask
   task wr(input [7:0] r, input [7:0] v, input [1:0] a);
      begin
         cm(`CMD_SET_REG_ADDR, r, `ACK_OK);
         cm(`CMD_SET_REG_DATA, v, a);
      end
   endtask
   // Slowest full ramp is 1020 cycles, so 3000 only trips on a stuck output
   task wcode(input [7:0] e);
      begin
         for (j = 0; j < 3000 && code !== e; j = j + 1) @(negedge mclk);
         `CHK(code, e)
         if (code !== e) report_and_stop;
      end
   endtask
   task settle(input integer k);
      begin
         repeat (2) @(negedge mclk);
         $display("test %0d done", k);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      err_count = 0;
      n_checks  = 0;
      nrst      = 1'b0;
      i         = $urandom(32'h6a50);
      strap     = $urandom;
      status    = 8'h00;
      temp      = 8'h10;
      repeat (4) @(posedge mclk);
      @(negedge mclk) nrst = 1'b1;
      `CHK({hot, code, pstate}, 17'h0)
      s0 = strap;
      repeat (20) @(negedge mclk);
      strap = ~s0;
      for (i = 0; i < 10; i = i + 1) rd(RIDX[8*i +: 8], `ACK_OK, dflt(RIDX[8*i +: 8]));
      for (i = 0; i < 5; i = i + 1) begin
         wr(RIDX[8*i +: 8], 8'h5a, `ACK_NOT_SUPPORTED);
         rd(RIDX[8*i +: 8], `ACK_OK, dflt(RIDX[8*i +: 8]));
      end
      rd(8'h23, `ACK_NOT_SUPPORTED, 8'h00);
      settle(1);
      status = $urandom;
      rd(`REG_STATUS_TWO, `ACK_OK, status);
      ps     = status;
      status = ~ps;
      rd(`REG_STATUS_TWO_SNAPSHOT, `ACK_OK, ps);
      settle(2);
      t22 = 8'h01 + $urandom % 8'hfd;
      wr(`REG_MAX_TEMP_LIMIT, t22, `ACK_OK);
      rd(`REG_MAX_TEMP_LIMIT, `ACK_OK, t22);
      temp = t22;
      settle(3);
      `CHK(hot, 1'b1)
      temp = t22 - 8'h01;
      settle(3);
      `CHK(hot, 1'b0)
      temp = 8'hff;
      `CHK(code, BOOT)
      lim = 8'h40 + $urandom % 8'h80;
      wr(`REG_MAX_OUTPUT_CODE, lim, `ACK_OK);
      cm(`CMD_SETVID_FAST, lim + 8'h01, `ACK_NOT_SUPPORTED);
      rd(`REG_PROGRAMMED_CODE, `ACK_OK, 8'h00);
      `CHK(code, BOOT)
      cm(`CMD_SETVID_FAST, lim, `ACK_OK);
      wcode(lim);
      vid = 8'h02 + $urandom % (lim - 8'h02);
      cm(`CMD_SETVID_SLOW, vid, `ACK_OK);
      wcode(vid);
      rd(`REG_PROGRAMMED_CODE, `ACK_OK, vid);
      settle(4);
      for (i = 0; i < 4; i = i + 1) begin
         t22 = (i < 3) ? OFS[8*i +: 8] : ($urandom % 8'h09) - 8'h04;
         wr(`REG_MARGIN_STEPS, t22, `ACK_OK);
         wcode(mg(vid, t22));
      end
      settle(5);
      ps = $urandom;
      cm(`CMD_SET_POWER_STATE, ps, `ACK_OK);
      `CHK(pstate, ps)
      bus.xfer(4'h0, `CMD_SET_POWER_STATE, ~ps, 1'b1, rsp, n);
      `CHK({n[3:0], pstate}, {4'd0, ps})
      wr(`REG_POWER_STATE, ~ps, `ACK_OK);
      `CHK(pstate, ~ps)
      rd(`REG_POWER_STATE, `ACK_OK, ~ps);
      cm(5'h1f, 8'h00, `ACK_NOT_SUPPORTED);
      // Mid-run reset: state returns to defaults and the strap is taken again
      nrst = 1'b0;
      repeat (2) @(negedge mclk);
      nrst = 1'b1;
      `CHK({hot, code, pstate}, 17'h0)
      s0 = strap;
      rd(`REG_MAX_CURRENT_LIMIT, `ACK_OK, s0);
      rd(`REG_MAX_TEMP_LIMIT, `ACK_OK, `RST_MAX_TEMP);
      settle(6);
      report_and_stop;
   end
endmodule // test_svid_register_bank
